// ===== design/iars_host.sv
// Host sequencer: powers up, configures and reads a converter chain
//
// Contract
// - After a toggle, keep the shift clock idle for the quiet interval.
// - Finish shifting the whole chain before the next results are ready.
// - Size chain and shift rate so readback fits about 266 us.
// - Pause shifting around each toggle, resume after, finish before ready.
// - Noncontinuous with long integration: defer readback to second end.
// - Noncontinuous: finish second results before the next round starts.
// - Noncontinuous: quiet around toggles, end before new results ready.
// - Hold every converter input low until the supplies are stable.
// - Start the master clock before issuing any reset.
// - Wait at least 250 ms, then reset low for at least 1 us.
// - Program the configuration register after reset, before conversions.
// - The quiet interval around each toggle is at least 10 us.
`timescale 1ns/1ps
`include "iars_defs.svh"
module iars_host
	import iars_pkg::*;
#(
	parameter int unsigned CHAIN_DEVS = 1,
	parameter int unsigned POR_CYC    = `IARS_POR_CYC,
	parameter int unsigned INT_CYC    = `IARS_INT_CYC,
	parameter int unsigned SCLK_HALF  = `IARS_SCLK_HALF,
	parameter int unsigned MCLK_HALF  = `IARS_MCLK_HALF,
	parameter int unsigned CFG_BITS   = `IARS_CFG_BITS,
	parameter int unsigned FIFO_DEPTH = 8
) (
	input  wire logic                         clk_sys,
	input  wire logic                         rst,
	input  wire logic                         supplies_stable,
	input  wire logic                         noncont_mode,
	input  wire logic                         fast_grade,
	input  wire logic                         wide_words,
	input  wire logic [CFG_BITS-1:0]          cfg_value,
	input  wire logic                         results_ready_n,
	input  wire logic                         results_data,
	output logic                              master_clk,
	output logic                              adc_reset_n,
	output logic                              integrate_side_select,
	output logic                              readout_shift_clock,
	output logic                              cfg_data,
	output logic [`IARS_WORD_WIDE-1:0]        word_data,
	output logic                              word_valid,
	input  wire logic                         word_ready,
	output logic                              running,
	output logic                              readback_busy,
	output logic                              overrun
);
	localparam int unsigned WW      = `IARS_WORD_WIDE;
	localparam int unsigned QUIET   = `IARS_QUIET_CYC;
	localparam int unsigned RST_CYC = `IARS_RST_CYC;
	localparam int unsigned BLK_END = INT_CYC - QUIET - 2*SCLK_HALF - 2;
	localparam int unsigned TOTAL   = CHAIN_DEVS * `IARS_WORDS_PER_DEV;

	// ==========================================================
	// Elaboration checks
	if (2*SCLK_HALF < `IARS_SYNC_MARGIN || SCLK_HALF > 255) begin : g_bad_sclk
		$error("Shift clock half period out of range");
	end
	// chain must fit the readback window
	if (CHAIN_DEVS == 0 || TOTAL > 65535 ||
	    CHAIN_DEVS * WW * `IARS_WORDS_PER_DEV * 2 * SCLK_HALF
	    > `IARS_WIN_CYC) begin : g_bad_chain
		$error("Chain does not fit the readback window");
	end
	if (INT_CYC <= 2*QUIET + 4*SCLK_HALF + 4) begin : g_bad_int
		$error("Integration period too short for quiet intervals");
	end
	if (CFG_BITS <= `IARS_CFG_FMT_POS || CFG_BITS > 63) begin : g_bad_cfg
		$error("Configuration word width out of range");
	end
	if (MCLK_HALF == 0 || MCLK_HALF > 65535) begin : g_bad_mclk
		$error("Master clock half period out of range");
	end

	// ==========================================================
	// Pin synchronisers
	logic [1:0] sup_sync_r, rdy_sync_r, dat_sync_r;
	logic       rdy_d_r, rdy_fall;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sup_sync_r <= 2'h0;
			rdy_sync_r <= 2'h3;
			dat_sync_r <= 2'h0;
			rdy_d_r    <= 1'b1;
		end else begin
			sup_sync_r <= {sup_sync_r[0], supplies_stable};
			rdy_sync_r <= {rdy_sync_r[0], results_ready_n};
			dat_sync_r <= {dat_sync_r[0], results_data};
			rdy_d_r    <= rdy_sync_r[1];
		end
	end
	assign rdy_fall = rdy_d_r && !rdy_sync_r[1];

	// ==========================================================
	// Sequencer state
	iars_pwr_t             pwr_r, pwr_nxt;
	iars_rd_t              rd_r, rd_nxt;
	logic [31:0]           gen_r, gen_nxt, int_r, int_nxt;
	logic [15:0]           mcnt_r, mcnt_nxt, word_r, word_nxt;
	logic [7:0]            half_r, half_nxt;
	logic [5:0]            bit_r, bit_nxt, wlen;
	logic [WW-1:0]         sh_r, sh_nxt, pd_r, pd_nxt;
	logic [CFG_BITS-1:0]   csh_r, csh_nxt, cfg_word;
	logic                  mclk_r, mclk_nxt, rstn_r, rstn_nxt;
	logic                  side_r, side_nxt, sclk_r, sclk_nxt;
	logic                  cfgd_r, cfgd_nxt, wide_r, wide_nxt;
	logic                  push_r, push_nxt, over_r, over_nxt;
	logic                  run_r, busy_r;
	logic                  fifo_in_ready, blocked, may_rise, fall;
	logic                  toggle, defer;
	logic [WW-1:0]         smp;

	always_comb begin
		pwr_nxt  = pwr_r;
		rd_nxt   = rd_r;
		gen_nxt  = gen_r;
		int_nxt  = int_r;
		mcnt_nxt = mcnt_r;
		word_nxt = word_r;
		half_nxt = half_r;
		bit_nxt  = bit_r;
		sh_nxt   = sh_r;
		pd_nxt   = pd_r;
		csh_nxt  = csh_r;
		mclk_nxt = mclk_r;
		rstn_nxt = rstn_r;
		side_nxt = side_r;
		sclk_nxt = sclk_r;
		cfgd_nxt = cfgd_r;
		wide_nxt = wide_r;
		over_nxt = over_r;
		push_nxt = push_r && !fifo_in_ready;
		toggle   = 1'b0;
		fall     = 1'b0;
		cfg_word = cfg_value;
		cfg_word[`IARS_CFG_FMT_POS] = wide_words;
		// word length from the format bit
		wlen = wide_r ? 6'(`IARS_WORD_WIDE) : 6'(`IARS_WORD_NARROW);
		smp  = {sh_r[WW-2:0], dat_sync_r[1]};
		// first ready delay per speed grade
		defer = noncont_mode && (INT_CYC > (fast_grade ?
			`IARS_NCDR1_FAST_CYC : `IARS_NCDR1_SLOW_CYC));
		// no rising edge near a toggle
		blocked  = (int_r < 32'(QUIET)) || (int_r >= 32'(BLK_END));
		may_rise = !push_r && ((pwr_r == ST_CFG) ||
			(pwr_r == ST_RUN && rd_r == RD_SHIFT && !blocked));

		// master clock runs once supplies are up
		if (pwr_r != ST_PWR_LOW) begin
			mcnt_nxt = mcnt_r + 16'h0001;
			if (mcnt_r == 16'(MCLK_HALF-1)) begin
				mcnt_nxt = 16'h0000;
				mclk_nxt = !mclk_r;
			end
		end

		// Shift clock engine, high phase completes unless supplies drop
		if (sclk_r) begin
			half_nxt = half_r + 8'h01;
			if (half_r == 8'(SCLK_HALF-1)) begin
				half_nxt = 8'h00;
				sclk_nxt = 1'b0;
				fall     = 1'b1;
			end
		end else if (may_rise) begin
			half_nxt = half_r + 8'h01;
			if (half_r == 8'(SCLK_HALF-1)) begin
				half_nxt = 8'h00;
				sclk_nxt = 1'b1;
			end
		end

		unique case (pwr_r)
			ST_PWR_LOW: begin
				if (sup_sync_r[1]) begin
					pwr_nxt  = ST_CLK_WAIT;
					rstn_nxt = 1'b1;
					gen_nxt  = 32'h0000_0000;
				end
			end
			// power-on wait before the reset pulse
			ST_CLK_WAIT: begin
				gen_nxt = gen_r + 32'h0000_0001;
				if (gen_r == 32'(POR_CYC-1)) begin
					pwr_nxt  = ST_RST_LOW;
					rstn_nxt = 1'b0;
					gen_nxt  = 32'h0000_0000;
				end
			end
			ST_RST_LOW: begin
				gen_nxt = gen_r + 32'h0000_0001;
				if (gen_r == 32'(RST_CYC-1)) begin
					pwr_nxt  = ST_CFG;
					rstn_nxt = 1'b1;
					csh_nxt  = cfg_word;
					cfgd_nxt = cfg_word[CFG_BITS-1];
					wide_nxt = wide_words;
					bit_nxt  = 6'h00;
				end
			end
			ST_CFG: begin
				if (fall) begin
					csh_nxt  = csh_r << 1;
					cfgd_nxt = csh_r[CFG_BITS-2];
					bit_nxt  = bit_r + 6'h01;
					if (bit_r == 6'(CFG_BITS-1)) begin
						pwr_nxt  = ST_RUN;
						cfgd_nxt = 1'b0;
						bit_nxt  = 6'h00;
						int_nxt  = 32'h0000_0000;
					end
				end
			end
			ST_RUN: begin
				int_nxt = int_r + 32'h0000_0001;
				if (int_r == 32'(INT_CYC-1)) begin
					int_nxt  = 32'h0000_0000;
					side_nxt = !side_r;
					toggle   = 1'b1;
				end
				if (fall && rd_r == RD_SHIFT) begin
					sh_nxt  = smp;
					bit_nxt = bit_r + 6'h01;
					if (bit_r == wlen - 6'h01) begin
						bit_nxt  = 6'h00;
						push_nxt = 1'b1;
						pd_nxt   = wide_r ? smp : {4'h0, smp[15:0]};
						word_nxt = word_r + 16'h0001;
						// stop after the last word of the chain
						if (word_r == 16'(TOTAL-1))
							rd_nxt = RD_IDLE;
					end
				end
				// noncontinuous with integration longer than the first ready delay defers to the second integration end
				if (rd_r == RD_ARM && toggle)
					rd_nxt = RD_SHIFT;
				if (rdy_fall) begin
					if (rd_r != RD_IDLE)
						over_nxt = 1'b1;
					else begin
						rd_nxt   = defer ? RD_ARM : RD_SHIFT;
						word_nxt = 16'h0000;
						bit_nxt  = 6'h00;
					end
				end
			end
			default: pwr_nxt = ST_PWR_LOW;
		endcase

		if (!sup_sync_r[1]) begin
			pwr_nxt  = ST_PWR_LOW;
			rd_nxt   = RD_IDLE;
			mcnt_nxt = 16'h0000;
			mclk_nxt = 1'b0;
			rstn_nxt = 1'b0;
			side_nxt = 1'b0;
			sclk_nxt = 1'b0;
			cfgd_nxt = 1'b0;
			half_nxt = 8'h00;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pwr_r  <= ST_PWR_LOW;
			rd_r   <= RD_IDLE;
			gen_r  <= 32'h0000_0000;
			int_r  <= 32'h0000_0000;
			mcnt_r <= 16'h0000;
			word_r <= 16'h0000;
			half_r <= 8'h00;
			bit_r  <= 6'h00;
			sh_r   <= '0;
			pd_r   <= '0;
			csh_r  <= '0;
			mclk_r <= 1'b0;
			rstn_r <= 1'b0;
			side_r <= 1'b0;
			sclk_r <= 1'b0;
			cfgd_r <= 1'b0;
			wide_r <= 1'b1;
			push_r <= 1'b0;
			over_r <= 1'b0;
			run_r  <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			pwr_r  <= pwr_nxt;
			rd_r   <= rd_nxt;
			gen_r  <= gen_nxt;
			int_r  <= int_nxt;
			mcnt_r <= mcnt_nxt;
			word_r <= word_nxt;
			half_r <= half_nxt;
			bit_r  <= bit_nxt;
			sh_r   <= sh_nxt;
			pd_r   <= pd_nxt;
			csh_r  <= csh_nxt;
			mclk_r <= mclk_nxt;
			rstn_r <= rstn_nxt;
			side_r <= side_nxt;
			sclk_r <= sclk_nxt;
			cfgd_r <= cfgd_nxt;
			wide_r <= wide_nxt;
			push_r <= push_nxt;
			over_r <= over_nxt;
			run_r  <= (pwr_nxt == ST_RUN);
			busy_r <= (rd_nxt != RD_IDLE);
		end
	end

	// ==========================================================
	// Word buffer, full buffer stalls the shift clock
	iars_fifo #(
		.WIDTH (WW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.in_data   (pd_r),
		.in_valid  (push_r),
		.in_ready  (fifo_in_ready),
		.out_data  (word_data),
		.out_valid (word_valid),
		.out_ready (word_ready)
	);

	assign master_clk            = mclk_r;
	assign adc_reset_n           = rstn_r;
	assign integrate_side_select = side_r;
	assign readout_shift_clock   = sclk_r;
	assign cfg_data              = cfgd_r;
	assign running               = run_r;
	assign readback_busy         = busy_r;
	assign overrun               = over_r;

	// ==========================================================
	// Checker helpers
	logic [31:0] since_sclk_r, since_tog_r, low_r, clk_run_r, bits_r;
	logic [7:0]  cfg_falls_r;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			since_sclk_r <= 32'hffff_ffff;
			since_tog_r  <= 32'hffff_ffff;
			low_r        <= 32'h0000_0000;
			clk_run_r    <= 32'h0000_0000;
			bits_r       <= 32'h0000_0000;
			cfg_falls_r  <= 8'h00;
		end else begin
			if (sclk_nxt != sclk_r)
				since_sclk_r <= 32'h0000_0000;
			else if (since_sclk_r != 32'hffff_ffff)
				since_sclk_r <= since_sclk_r + 32'h0000_0001;
			if (side_nxt != side_r)
				since_tog_r <= 32'h0000_0000;
			else if (since_tog_r != 32'hffff_ffff)
				since_tog_r <= since_tog_r + 32'h0000_0001;
			low_r <= rstn_r ? 32'h0000_0000 : low_r + 32'h0000_0001;
			if (pwr_r == ST_PWR_LOW)
				clk_run_r <= 32'h0000_0000;
			else if (clk_run_r != 32'hffff_ffff)
				clk_run_r <= clk_run_r + 32'h0000_0001;
			if (rd_r == RD_IDLE && rd_nxt != RD_IDLE)
				bits_r <= 32'h0000_0000;
			else if (rd_r == RD_SHIFT && fall)
				bits_r <= bits_r + 32'h0000_0001;
			if (pwr_r == ST_PWR_LOW)
				cfg_falls_r <= 8'h00;
			else if (pwr_r == ST_CFG && fall)
				cfg_falls_r <= cfg_falls_r + 8'h01;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	chk_quiet_pre: assert property (
		$changed(side_r) |-> since_sclk_r >= 32'(QUIET))
		else $error("Shift clock active inside quiet interval before toggle");
	chk_quiet_post: assert property (
		$changed(sclk_r) && pwr_r == ST_RUN |-> since_tog_r >= 32'(QUIET))
		else $error("Shift clock active inside quiet interval after toggle");
	chk_pins_low: assert property (
		pwr_r == ST_PWR_LOW |->
		!(mclk_r || rstn_r || side_r || sclk_r || cfgd_r))
		else $error("Converter input driven before supplies stable");
	chk_por_wait: assert property (
		$fell(rstn_r) && pwr_r == ST_RST_LOW |-> clk_run_r >= 32'(POR_CYC))
		else $error("Reset issued before the power-on wait");
	chk_rst_width: assert property (
		$rose(rstn_r) && pwr_r == ST_CFG |-> low_r >= 32'(RST_CYC))
		else $error("Reset pulse too short");
	chk_cfg_first: assert property (
		$rose(run_r) |-> cfg_falls_r == 8'(CFG_BITS))
		else $error("Run entered without a full configuration word");
	chk_word_total: assert property (
		$fell(busy_r) && run_r |->
		bits_r == 32'(TOTAL) * (wide_r ? 32'h0000_0014 : 32'h0000_0010))
		else $error("Readback bit count wrong");
	chk_overrun_flag: assert property (
		rdy_fall && run_r && rd_r != RD_IDLE |=> over_r)
		else $error("Late readback not flagged");
	chk_defer_start: assert property (
		rd_r == RD_ARM ##1 rd_r == RD_SHIFT |-> since_tog_r == 32'h0000_0000)
		else $error("Deferred readback not started at the toggle");
	chk_fifo_stall: assert property (
		!sclk_r && push_r && !fifo_in_ready |=> !sclk_r)
		else $error("Shift clock rose while buffer full");
endmodule

// ===== design/iars_defs.svh
// Timing, width and layout constants of the readout sequencer
`ifndef IARS_DEFS_SVH
`define IARS_DEFS_SVH

// ==========================================================
// Clock rate
`define IARS_CLK_MHZ         250

// ==========================================================
// Power-up and reset timing
`define IARS_POR_MS          250
`define IARS_POR_CYC         (`IARS_POR_MS * 1000 * `IARS_CLK_MHZ)
`define IARS_RST_US          1
`define IARS_RST_CYC         (`IARS_RST_US * `IARS_CLK_MHZ)

// ==========================================================
// Readback timing
`define IARS_QUIET_US        10
`define IARS_QUIET_CYC       (`IARS_QUIET_US * `IARS_CLK_MHZ)
`define IARS_WIN_US          266
`define IARS_WIN_CYC         (`IARS_WIN_US * `IARS_CLK_MHZ)
`define IARS_NCDR1_SLOW_NS   276500
`define IARS_NCDR1_FAST_NS   138200
`define IARS_NCDR1_SLOW_CYC  (`IARS_NCDR1_SLOW_NS * `IARS_CLK_MHZ / 1000)
`define IARS_NCDR1_FAST_CYC  (`IARS_NCDR1_FAST_NS * `IARS_CLK_MHZ / 1000)
`define IARS_INT_US          400
`define IARS_INT_CYC         (`IARS_INT_US * `IARS_CLK_MHZ)
`define IARS_SCLK_HALF       8
`define IARS_MCLK_HALF       25
`define IARS_SYNC_MARGIN     10

// ==========================================================
// Word and configuration layout
`define IARS_WORD_WIDE       20
`define IARS_WORD_NARROW     16
`define IARS_WORDS_PER_DEV   32
`define IARS_CFG_BITS        12
`define IARS_CFG_FMT_POS     8

`endif

// ===== design/iars_pkg.sv
// State types of the readout sequencer
package iars_pkg;

	// ==========================================================
	// Power-up and run sequence
	typedef enum logic [2:0] {
		ST_PWR_LOW  = 3'b000,
		ST_CLK_WAIT = 3'b001,
		ST_RST_LOW  = 3'b010,
		ST_CFG      = 3'b011,
		ST_RUN      = 3'b100
	} iars_pwr_t;

	// ==========================================================
	// Readback sequence
	typedef enum logic [1:0] {
		RD_IDLE  = 2'b00,
		RD_ARM   = 2'b01,
		RD_SHIFT = 2'b10
	} iars_rd_t;

endpackage

// ===== design/iars_fifo.sv
// Word FIFO with registered output stage
`timescale 1ns/1ps
module iars_fifo #(
	parameter int unsigned WIDTH = 20,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("FIFO depth must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
	logic [AW:0]      cnt_r, cnt_nxt;
	logic [WIDTH-1:0] out_r, out_nxt;
	logic             val_r, val_nxt;
	logic             push, load;

	// ==========================================================
	// Pointer and output stage update
	always_comb begin
		push    = in_valid && (cnt_r != (AW+1)'(DEPTH));
		load    = (cnt_r != '0) && (!val_r || out_ready);
		wr_nxt  = push ? wr_r + 1'b1 : wr_r;
		rd_nxt  = load ? rd_r + 1'b1 : rd_r;
		cnt_nxt = cnt_r;
		if (push && !load)
			cnt_nxt = cnt_r + 1'b1;
		else if (load && !push)
			cnt_nxt = cnt_r - 1'b1;
		out_nxt = out_r;
		val_nxt = val_r;
		if (load) begin
			out_nxt = mem_r[rd_r];
			val_nxt = 1'b1;
		end else if (out_ready) begin
			val_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
			out_r <= '0;
			val_r <= 1'b0;
		end else begin
			wr_r  <= wr_nxt;
			rd_r  <= rd_nxt;
			cnt_r <= cnt_nxt;
			out_r <= out_nxt;
			val_r <= val_nxt;
		end
	end

	// ==========================================================
	// Storage
	always_ff @(posedge clk_sys) begin
		if (push)
			mem_r[wr_r] <= in_data;
	end

	assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
	assign out_data  = out_r;
	assign out_valid = val_r;
endmodule

// ===== dv/iars_integrate_side_select_model.sv
// Behavioural converter at the far side of the readout sequencer
`timescale 1ns/1ps
module iars_adc_model #(
	parameter int unsigned POR_NS   = 280,
	parameter int unsigned READY_NS = 4000
) (
	input  wire logic        clk_sys,
	input  wire logic        supplies_stable,
	input  wire logic        master_clk,
	input  wire logic        adc_reset_n,
	input  wire logic        integrate_side_select,
	input  wire logic        readout_shift_clock,
	input  wire logic        cfg_data,
	output logic             results_ready_n,
	output logic             results_data,
	output logic [11:0]      cfg_word,
	output int               viol_cnt
);
	logic [19:0] words[$];
	logic        bits[$];
	realtime     t_clk;
	realtime     t_rst;
	realtime     t_tog   = -1.0e6;
	realtime     t_sclk  = -1.0e6;
	int          n_cfg   = 0;
	int          n_mclk  = 0;
	logic        sup_d   = 1'b1;
	logic        rst_low = 1'b0;
	logic        rd_on   = 1'b0;

	initial begin
		results_ready_n = 1'b1;
		results_data = 1'b0;
		cfg_word = '0;
		viol_cnt = 0;
	end

	task automatic viol(input string what);
		viol_cnt++;
		$display("[ERR] converter %s exp 0 got 1", what);
	endtask

	// ====
	// Power-up
	// inputs low while supplies unstable
	always @(posedge clk_sys) begin
		if (!sup_d && !supplies_stable && {master_clk, adc_reset_n,
			integrate_side_select, readout_shift_clock, cfg_data} !== 5'h00)
			viol("inputs_low");
		sup_d <= supplies_stable;
	end
	always @(negedge supplies_stable) begin
		n_mclk = 0;
		rst_low = 1'b0;
	end
	always @(master_clk) if (supplies_stable) begin
		if (n_mclk == 0) t_clk = $realtime;
		n_mclk++;
	end
	always @(negedge adc_reset_n) if (supplies_stable) begin
		if (n_mclk < 2 || $realtime - t_clk < POR_NS) viol("por_wait");
		rst_low = 1'b1;
		t_rst = $realtime;
	end
	always @(posedge adc_reset_n) if (rst_low) begin
		if ($realtime - t_rst < 1000.0) viol("reset_width");
		rst_low = 1'b0;
		n_cfg = 0;
	end

	// ====
	// Shift clock and toggles
	// quiet after a toggle
	always @(readout_shift_clock) begin
		if ($realtime - t_tog < 10000.0) viol("quiet_after");
		t_sclk = $realtime;
		if (readout_shift_clock === 1'b1 && n_cfg < 12) begin
			cfg_word = {cfg_word[10:0], cfg_data};
			n_cfg++;
		end
	end
	always @(integrate_side_select) if (adc_reset_n === 1'b1) begin
		if ($realtime - t_sclk < 10000.0) viol("quiet_before");
		if (n_cfg != 12) viol("cfg_missing");
		t_tog = $realtime;
		fork
			ready_after();
		join_none
	end

	// ready a fixed delay after integration
	task automatic ready_after();
		logic [19:0] w;
		#(READY_NS);
		if (adc_reset_n !== 1'b1 || words.size() < 32) return;
		if (bits.size() != 0) viol("readback_late");
		repeat (32) begin
			w = words.pop_front();
			for (int i = 19; i >= (cfg_word[8] ? 0 : 4); i--)
				bits.push_back(w[i]);
		end
		results_data = bits[0];
		#400;
		results_ready_n = 1'b0;
		rd_on = 1'b1;
	endtask

	// next bit on falling shift edge
	always @(negedge readout_shift_clock) if (rd_on) begin
		results_ready_n = 1'b1;
		void'(bits.pop_front());
		rd_on = bits.size() != 0;
		results_data = rd_on ? bits[0] : ~results_data;
	end
endmodule

// ===== dv/iars_host_tb.sv
// Self-checking bench of the readout sequencer
`timescale 1ns/1ps
`include "iars_defs.svh"
module iars_host_tb;
	localparam int unsigned POR_CYC = 100;
	localparam int unsigned INT_CYC = 18000;

	logic        clk_sys, rst, supplies_stable, noncont_mode, fast_grade;
	logic        wide_words, word_ready, stall, results_ready_n;
	logic        results_data, master_clk, adc_reset_n, cfg_data;
	logic        integrate_side_select, readout_shift_clock, word_valid;
	logic        running, readback_busy, overrun;
	logic [11:0] cfg_value, cfg_word;
	logic [19:0] word_data;
	logic [19:0] exp_q[$];
	int          viol_cnt;
	int          n_errors = 0;
	int          cmp_count = 0;
	int          cyc = 0;

	iars_host #(.POR_CYC(POR_CYC), .INT_CYC(INT_CYC)) i_iars_host (
		.clk_sys(clk_sys), .rst(rst), .supplies_stable(supplies_stable),
		.noncont_mode(noncont_mode), .fast_grade(fast_grade),
		.wide_words(wide_words), .cfg_value(cfg_value),
		.results_ready_n(results_ready_n), .results_data(results_data),
		.master_clk(master_clk), .adc_reset_n(adc_reset_n),
		.integrate_side_select(integrate_side_select),
		.readout_shift_clock(readout_shift_clock), .cfg_data(cfg_data),
		.word_data(word_data), .word_valid(word_valid),
		.word_ready(word_ready), .running(running),
		.readback_busy(readback_busy), .overrun(overrun));

	iars_adc_model #(.POR_NS((POR_CYC - 30) * 4)) i_iars_adc_model (
		.clk_sys(clk_sys), .supplies_stable(supplies_stable),
		.master_clk(master_clk), .adc_reset_n(adc_reset_n),
		.integrate_side_select(integrate_side_select),
		.readout_shift_clock(readout_shift_clock), .cfg_data(cfg_data),
		.results_ready_n(results_ready_n), .results_data(results_data),
		.cfg_word(cfg_word), .viol_cnt(viol_cnt));

	// ====
	// Clock, timeout, helpers
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 100000) begin
			n_errors++;
			$display("[ERR] run_length exp done got hang");
			complete_run();
		end
	end

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, s);
		end
	endtask

	task automatic complete_run();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ====
	// Word sink with random stalls
	always @(posedge clk_sys) begin
		if (rst === 1'b0 && word_valid === 1'b1 && word_ready === 1'b1) begin
			if (exp_q.size() == 0)
				chk("word_extra", 0, 1);
			else
				chk("word_data", exp_q.pop_front(), word_data);
		end
		#1 word_ready = !stall && ($urandom % 4 != 0);
	end

	// ====
	// One power-up, config and readback run
	task automatic session(input logic wide, input logic nc, input int nrb);
		logic [19:0] w;
		logic [11:0] ec;
		logic        p;
		int          n;
		int          nm;
		rst = 1'b1;
		supplies_stable = 1'b0;
		wide_words = wide;
		noncont_mode = nc;
		fast_grade = nc;
		cfg_value = 12'($urandom);
		ec = cfg_value;
		ec[`IARS_CFG_FMT_POS] = wide;
		repeat (nrb * 32) begin
			w = 20'($urandom);
			i_iars_adc_model.words.push_back(w);
			exp_q.push_back(wide ? w : {4'h0, w[19:4]});
		end
		step(4);
		rst = 1'b0;
		step(20);
		chk("pins_low", 0, {master_clk, adc_reset_n, cfg_data,
			integrate_side_select, readout_shift_clock});
		supplies_stable = 1'b1;
		while (adc_reset_n !== 1'b1) step(1);
		n = 0;
		nm = 0;
		p = master_clk;
		while (adc_reset_n === 1'b1) begin
			step(1);
			n++;
			nm += int'(master_clk !== p);
			p = master_clk;
		end
		chk("mclk_first", 1, nm >= 2);
		chk("por_wait", 1, n >= POR_CYC);
		n = 0;
		while (adc_reset_n === 1'b0) begin
			step(1);
			n++;
		end
		chk("reset_low", `IARS_RST_CYC, n);
		while (running !== 1'b1) step(1);
		chk("cfg_word", ec, cfg_word);
		for (int k = 0; k < nrb; k++) begin
			while (readback_busy !== 1'b1) step(1);
			if (k == 0 && wide) begin
				stall = 1'b1;
				step(5500);
				n = 0;
				p = readout_shift_clock;
				repeat (500) begin
					step(1);
					n += int'(readout_shift_clock && !p);
					p = readout_shift_clock;
				end
				chk("shift_when_full", 0, n);
				stall = 1'b0;
			end
			while (readback_busy === 1'b1) step(1);
			step(60);
			chk("words_left", (nrb - k - 1) * 32, exp_q.size());
		end
		chk("overrun", 0, overrun);
		chk("model_viol", 0, viol_cnt);
	endtask

	initial begin
		stall = 1'b0;
		word_ready = 1'b0;
		void'($urandom(32654));
		session(1'b1, 1'b0, 2);
		session(1'b0, 1'b1, 1);
		complete_run();
	end
endmodule
